// [hdl/asc_config_regs.sv]
// Serially programmed configuration register bank with serial readback
`timescale 1ns/1ps
module asc_config_regs import asc_pkg::*; (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Serial programming pins (asynchronous to ref_clk)
  input  wire logic        serialEnableN,
  input  wire logic        serialClk,
  input  wire logic        serialData,
  input  wire logic        resetPin,
  // Static strap pins (asynchronous)
  input  wire logic        format_select_pin_lvds,
  input  wire logic        format_select_pin_twos,
  // Core side, same clock
  input  wire logic        overrangeIn,
  input  wire logic [2:0]  testPatternSel,
  // Shared readback pin
  output logic             overrange_or_serial_out_pin,
  // Decoded configuration
  output asc_cfg_type      cfg
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [SYNC_WIDTH-1:0] pinRaw;
  logic [SYNC_WIDTH-1:0] sync1_q, sync2_q, sync3_q;
  logic [SYNC_WIDTH-1:0] filt_d, filt_q;

  assign pinRaw = {format_select_pin_twos, format_select_pin_lvds, resetPin,
                   serialData, serialClk, serialEnableN};

  // Filtered level moves only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
      always_comb begin
        filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : filt_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Stages start at idle levels so no false enable follows reset
      sync1_q <= 6'b00_0001;
      sync2_q <= 6'b00_0001;
      sync3_q <= 6'b00_0001;
      filt_q  <= 6'b00_0001;  // Enable idles high
    end else begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  logic senActive, sclkRise, sdataLvl, pinReset;
  assign senActive = ~filt_q[0];
  assign sclkRise  = ~filt_q[1] & filt_d[1];
  assign sdataLvl  = filt_d[2];
  assign pinReset  = filt_q[3];

  // ---------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------
  localparam int NREG = 9;
  localparam logic [7:0] REG_ADDR [NREG] = '{ADDR_RESET_READ,
    ADDR_RATE_MODE, ADDR_POWER, ADDR_OUT_IF, ADDR_CLK_PLACE,
    ADDR_NUM_FORMAT, ADDR_PAT_LOW, ADDR_PAT_HIGH, ADDR_OFFSET_LOOP};
  localparam logic [7:0] REG_MASK [NREG] = '{MASK_RESET_READ,
    MASK_RATE_MODE, MASK_POWER, MASK_OUT_IF, MASK_CLK_PLACE,
    MASK_NUM_FORMAT, MASK_PAT_LOW, MASK_PAT_HIGH, MASK_OFFSET_LOOP};

  logic [7:0] regs_q [NREG];
  logic [7:0] regs_d [NREG];
  logic       swReset_d, swReset_q;

  // Frame shifter state
  logic [4:0]  bitCnt_d, bitCnt_q;
  logic [15:0] shiftIn_d, shiftIn_q;
  logic [7:0]  readShift_d, readShift_q;
  logic        readout;
  logic [7:0]  addrNow;
  logic [7:0]  readVal;
  logic        wrStrobe;

  assign readout = regs_q[0][BIT_READOUT];
  assign addrNow = {shiftIn_q[6:0], sdataLvl};

  // Register look-up; unmapped addresses read as zero
  always_comb begin
    readVal = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (addrNow == REG_ADDR[i]) begin
        readVal = regs_q[i];
      end
    end
  end

  // Frame sequencing: 8 address bits then 8 data bits, MSB first
  always_comb begin
    bitCnt_d    = bitCnt_q;
    shiftIn_d   = shiftIn_q;
    readShift_d = readShift_q;
    wrStrobe    = 1'b0;
    if (!senActive) begin
      bitCnt_d = 5'd0;  // Enable high aborts a partial frame
    end else if (sclkRise && bitCnt_q != FRAME_END) begin
      shiftIn_d = {shiftIn_q[14:0], sdataLvl};
      bitCnt_d  = bitCnt_q + 5'd1;
      if (bitCnt_q == FRAME_ADDR_END - 5'd1) begin
        readShift_d = readVal;  // [RULE1]
      end else if (bitCnt_q >= FRAME_ADDR_END) begin
        readShift_d = {readShift_q[6:0], 1'b0};
      end
      if (bitCnt_q == FRAME_END - 5'd1) begin
        wrStrobe = 1'b1;
      end
    end
  end

  // Write path; while readback is on only the reset/readback word is
  // writable, so software can still leave readback mode
  always_comb begin
    logic [7:0] wAddr;
    logic [7:0] wData;
    wAddr     = shiftIn_d[15:8];
    wData     = shiftIn_d[7:0];
    swReset_d = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (swReset_q || pinReset) begin
      for (int i = 0; i < NREG; i++) begin
        regs_d[i] = REG_RESET_VALUE;  // [RULE16]
      end
    end else if (wrStrobe) begin
      for (int i = 0; i < NREG; i++) begin
        if (wAddr == REG_ADDR[i] && (!readout || i == 0)) begin
          regs_d[i] = wData & REG_MASK[i];  // [RULE6]
        end
      end
      // Reset bit is never stored, so it reads back as zero
      swReset_d = (wAddr == ADDR_RESET_READ) && wData[BIT_SW_RESET];  // [RULE16]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= REG_RESET_VALUE;
      end
      swReset_q   <= 1'b0;
      bitCnt_q    <= 5'd0;
      shiftIn_q   <= 16'h0000;
      readShift_q <= 8'h00;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= regs_d[i];
      end
      swReset_q   <= swReset_d;
      bitCnt_q    <= bitCnt_d;
      shiftIn_q   <= shiftIn_d;
      readShift_q <= readShift_d;
    end
  end

  // ---------------------------------------------------------------------
  // Decode of edge placement codes
  // ---------------------------------------------------------------------
  function automatic asc_edge_type riseDecode(input logic [2:0] code,
                                              input logic       lvds);
    asc_edge_type e;
    e = EDGE_DEFAULT;
    case (code)
      EDGE_DEFAULT_0: e = EDGE_DEFAULT;
      EDGE_DEFAULT_1: e = EDGE_DEFAULT;
      EDGE_CODE_5:    e = EDGE_PLUS4;                          // [RULE8]
      EDGE_CODE_6:    e = lvds ? EDGE_ALIGNED : EDGE_PLUS6;    // [RULE9]
      EDGE_CODE_7:    e = lvds ? EDGE_MINUS4 : EDGE_ALIGNED;   // [RULE8]
      default:        e = EDGE_DEFAULT;                        // [RULE19]
    endcase
    return e;
  endfunction : riseDecode

  // ---------------------------------------------------------------------
  // Decoded controls, registered so every output is a flip-flop
  // ---------------------------------------------------------------------
  asc_cfg_type cfg_d;
  logic        serialOut_d;
  logic [1:0]  ifSel, fmtSel;
  logic [2:0]  fallCode;

  assign ifSel    = regs_q[3][POS_IF_SEL +: 2];
  assign fmtSel   = regs_q[5][POS_FORMAT +: 2];
  assign fallCode = regs_q[4][POS_FALL_CODE +: 3];

  always_comb begin
    cfg_d.reducedRate     = regs_q[1][BIT_REDUCED];     // [RULE2]
    cfg_d.globalPowerDown = regs_q[2][BIT_PD_GLOBAL];   // [RULE3]
    // Standby idles the core alone; global power-down covers it too
    cfg_d.coreStandby     = regs_q[2][BIT_STANDBY]
                          | regs_q[2][BIT_PD_GLOBAL];   // [RULE4]
    cfg_d.outputDriverOff = regs_q[2][BIT_DRIVER_OFF]
                          | regs_q[2][BIT_PD_GLOBAL];   // [RULE5]
    // Unlisted interface code falls back to the strap pin
    case (ifSel)
      SEL_FORCE_A: cfg_d.lvdsMode = 1'b1;               // [RULE7]
      SEL_FORCE_B: cfg_d.lvdsMode = 1'b0;               // [RULE7]
      default:     cfg_d.lvdsMode = filt_q[4];          // [RULE7]
    endcase
    cfg_d.risePlace = riseDecode(regs_q[4][POS_RISE_CODE +: 3],
                                 cfg_d.lvdsMode);
    // Only default falling codes are defined; all others map there too
    case (fallCode)
      EDGE_DEFAULT_0: cfg_d.fallPlace = EDGE_DEFAULT;   // [RULE10]
      default:        cfg_d.fallPlace = EDGE_DEFAULT;   // [RULE19]
    endcase
    case (fmtSel)
      SEL_FORCE_A: cfg_d.twosComplement = 1'b1;         // [RULE11]
      SEL_FORCE_B: cfg_d.twosComplement = 1'b0;         // [RULE11]
      default:     cfg_d.twosComplement = filt_q[5];    // [RULE11]
    endcase
    cfg_d.customPattern   = {regs_q[7][5:0], regs_q[6]};  // [RULE12] [RULE13]
    cfg_d.customPatternOn = (testPatternSel == TEST_CUSTOM);  // [RULE17]
    cfg_d.offsetCorrOn    = regs_q[8][BIT_OFFSET_CORR];   // [RULE14] [RULE15]
    // Shared pin carries overrange unless readback is enabled
    serialOut_d = readout ? readShift_q[7] : overrangeIn;  // [RULE1]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg                         <= '0;
      overrange_or_serial_out_pin <= 1'b0;
    end else begin
      cfg                         <= cfg_d;
      overrange_or_serial_out_pin <= serialOut_d;
    end
  end

endmodule : asc_config_regs

// [pkg/asc_pkg.sv]
// Constants, field layouts and types of the serial configuration bank
// How it works
// RULE1: Readback bit 0 turns serial readout off; 1 routes read data to overrange pin.
// RULE2: Bit 2 of 0x20 enables reduced-rate mode; host sets it at or below 100 MSPS.
// RULE3: Bit 2 of 0x3F powers down core, references and drivers; slow wake-up.
// RULE4: Bit 1 of 0x3F powers down only the core; quick wake-up.
// RULE5: Bit 0 of 0x3F: 0 keeps output drivers on, 1 powers them down.
// RULE6: Bits 6:5 of 0x3F are unused; host leaves them zero.
// RULE7: Bits 7:6 of 0x41: 00 pin decides, 10 LVDS, 11 CMOS.
// RULE8: LVDS rising edge: 000/100 default, 101 +4/26, 110 aligned, 111 -4/26.
// RULE9: CMOS rising edge: 000/100 default, 101 +4/26, 110 +6/26, 111 aligned.
// RULE10: Bits 4:2 of 0x44 set falling edge; 000 and 100 give default.
// RULE11: Bits 2:1 of 0x50: 00 pin decides, 10 two's complement, 11 offset binary.
// RULE12: Register 0x51 holds the low eight bits of the user pattern.
// RULE13: Bits 5:0 of 0x52 hold the upper six bits of the user pattern.
// RULE14: Bit 6 of 0x53 at 0 keeps offset correction disabled.
// RULE15: Bit 6 of 0x53 at 1 enables offset correction.
// RULE16: Software reset bit returns all registers to default and clears itself.
// RULE17: User pattern drives outputs only while test pattern code is 101.
// RULE18: Host writes zero to fixed bits and uses only listed selection codes.
// RULE19: Unlisted clock edge placement codes act as the default placement.
package asc_pkg;

  // ---------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_RESET_READ  = 8'h00;
  localparam logic [7:0] ADDR_RATE_MODE   = 8'h20;
  localparam logic [7:0] ADDR_POWER       = 8'h3f;
  localparam logic [7:0] ADDR_OUT_IF      = 8'h41;
  localparam logic [7:0] ADDR_CLK_PLACE   = 8'h44;
  localparam logic [7:0] ADDR_NUM_FORMAT  = 8'h50;
  localparam logic [7:0] ADDR_PAT_LOW     = 8'h51;
  localparam logic [7:0] ADDR_PAT_HIGH    = 8'h52;
  localparam logic [7:0] ADDR_OFFSET_LOOP = 8'h53;

  // ---------------------------------------------------------------------
  // Writable bit masks; bits outside a mask read back as zero
  // ---------------------------------------------------------------------
  localparam logic [7:0] MASK_RESET_READ  = 8'h01;
  localparam logic [7:0] MASK_RATE_MODE   = 8'h04;
  localparam logic [7:0] MASK_POWER       = 8'h07;
  localparam logic [7:0] MASK_OUT_IF      = 8'hc0;
  localparam logic [7:0] MASK_CLK_PLACE   = 8'hfc;
  localparam logic [7:0] MASK_NUM_FORMAT  = 8'h06;
  localparam logic [7:0] MASK_PAT_LOW     = 8'hff;
  localparam logic [7:0] MASK_PAT_HIGH    = 8'h3f;
  localparam logic [7:0] MASK_OFFSET_LOOP = 8'h40;

  // Reset value shared by every register
  localparam logic [7:0] REG_RESET_VALUE  = 8'h00;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int BIT_SW_RESET    = 7;
  localparam int BIT_READOUT     = 0;
  localparam int BIT_REDUCED     = 2;
  localparam int BIT_PD_GLOBAL   = 2;
  localparam int BIT_STANDBY     = 1;
  localparam int BIT_DRIVER_OFF  = 0;
  localparam int POS_IF_SEL      = 6;
  localparam int POS_RISE_CODE   = 5;
  localparam int POS_FALL_CODE   = 2;
  localparam int POS_FORMAT      = 1;
  localparam int BIT_OFFSET_CORR = 6;

  // ---------------------------------------------------------------------
  // Codes and frame geometry
  // ---------------------------------------------------------------------
  localparam logic [1:0] SEL_BY_PIN     = 2'b00;
  localparam logic [1:0] SEL_FORCE_A    = 2'b10;  // LVDS / two's complement
  localparam logic [1:0] SEL_FORCE_B    = 2'b11;  // CMOS / offset binary
  localparam logic [2:0] EDGE_DEFAULT_0 = 3'b000;
  localparam logic [2:0] EDGE_DEFAULT_1 = 3'b100;
  localparam logic [2:0] EDGE_CODE_5    = 3'b101;
  localparam logic [2:0] EDGE_CODE_6    = 3'b110;
  localparam logic [2:0] EDGE_CODE_7    = 3'b111;
  localparam logic [2:0] TEST_CUSTOM    = 3'b101;
  localparam logic [4:0] FRAME_ADDR_END = 5'd8;
  localparam logic [4:0] FRAME_END      = 5'd16;
  localparam int         SYNC_WIDTH     = 6;

  // Resolved output clock edge placement
  typedef enum logic [2:0] {
    EDGE_DEFAULT = 3'b000,
    EDGE_PLUS4   = 3'b001,
    EDGE_PLUS6   = 3'b010,
    EDGE_ALIGNED = 3'b011,
    EDGE_MINUS4  = 3'b100
  } asc_edge_type;

  // Decoded controls handed to the converter core and output stage
  typedef struct packed {
    logic         reducedRate;
    logic         globalPowerDown;
    logic         coreStandby;
    logic         outputDriverOff;
    logic         lvdsMode;
    asc_edge_type risePlace;
    asc_edge_type fallPlace;
    logic         twosComplement;
    logic         customPatternOn;
    logic [13:0]  customPattern;
    logic         offsetCorrOn;
  } asc_cfg_type;

endpackage : asc_pkg

// [sim/asc_config_regs_props.sv]
// Port-level checks of the serial configuration bank
`timescale 1ns/1ps
module asc_config_regs_props import asc_pkg::*; (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Host and reset pins
  input wire logic        serialEnableN,
  input wire logic        resetPin,
  // Core side
  input wire logic [2:0]  testPatternSel,
  input wire asc_cfg_type cfg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Pin states; eight cycles cover the pin synchronisers
  // ---------------------------------------------------------------
  sequence s_quiet;
    serialEnableN && !resetPin;
  endsequence
  sequence s_hw_reset;
    resetPin;
  endsequence

  a_global_core_off:
    assert property (cfg.globalPowerDown |-> cfg.coreStandby)
    else $error("global power-down left the core awake");
  a_global_drv_off:
    assert property (cfg.globalPowerDown |-> cfg.outputDriverOff)
    else $error("global power-down left the drivers on");
  a_fall_default:
    assert property (cfg.fallPlace == EDGE_DEFAULT)
    else $error("falling edge left its default place");
  a_cmos_no_minus:
    assert property (!cfg.lvdsMode |-> cfg.risePlace != EDGE_MINUS4)
    else $error("negative shift seen in CMOS mode");
  a_lvds_no_plus6:
    assert property (cfg.lvdsMode |-> cfg.risePlace != EDGE_PLUS6)
    else $error("six step shift seen in LVDS mode");
  a_pattern_on_code:
    assert property (!$past(rst) |-> cfg.customPatternOn ==
                     ($past(testPatternSel) == TEST_CUSTOM))
    else $error("pattern enable does not follow its code");
  // Held registers may only move while a frame or reset is active
  a_idle_regs_hold:
    assert property (s_quiet [*8] |=> $stable(cfg.customPattern) &&
                     $stable(cfg.offsetCorrOn) && $stable(cfg.reducedRate))
    else $error("stored field changed with the host idle");
  a_hw_reset_clear:
    assert property (s_hw_reset [*8] |-> !cfg.reducedRate &&
                     !cfg.offsetCorrOn && cfg.customPattern == 14'h0000)
    else $error("fields not cleared under hardware reset");
endmodule : asc_config_regs_props

// [sim/asc_host_model.sv]
// Behavioural host that runs frames on the serial programming pins
`timescale 1ns/1ps
module asc_host_model (
  // Pacing clock
  input  wire logic ref_clk,
  // Serial programming pins
  output logic      serialEnableN,
  output logic      serialClk,
  output logic      serialData,
  // Shared readback pin
  input  wire logic readPin
);
  // Five cycles a level keeps each phase above the four-cycle minimum
  localparam int PHASE_CYCLES = 5;

  initial begin
    serialEnableN = 1'b1;
    serialClk     = 1'b0;
    serialData    = 1'b1;
  end

  // One frame, address then data, MSB first; read bits taken late
  task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] word;
    word  = {addr, wdata};
    rdata = 8'h00;
    @(posedge ref_clk);
    #1 serialEnableN = 1'b0;
    for (int b = 0; b < 16; b++) begin
      serialData = word[15-b];
      repeat (PHASE_CYCLES) @(posedge ref_clk);
      #1 if (b >= 8) rdata[15-b] = readPin;
      serialClk = 1'b1;
      repeat (PHASE_CYCLES) @(posedge ref_clk);
      #1 serialClk = 1'b0;
    end
    repeat (PHASE_CYCLES) @(posedge ref_clk);
    // Released line shows the inverse so no stale bit looks valid
    #1 serialEnableN = 1'b1;
    serialData = ~serialData;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask : xfer
endmodule : asc_host_model

// [sim/tb_asc_config_regs.sv]
// Self-checking bench of the serial configuration bank
`timescale 1ns/1ps
module tb_asc_config_regs;
  import asc_pkg::*;
  `define CHECK(what, exp, got) begin checkCount++; \
    if ((got) !== (exp)) begin badCount++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end

  logic        ref_clk = 1'b0, rst = 1'b1, resetPin = 1'b0;
  logic        strapLvds = 1'b0, strapTwos = 1'b0, overrangeIn = 1'b0;
  logic [2:0]  testPatternSel = 3'b000;
  logic        serialEnableN, serialClk, serialData, pinOut;
  asc_cfg_type cfg;
  int          badCount = 0, checkCount = 0;

  always #5 ref_clk = ~ref_clk;

  asc_config_regs asc_config_regs_i (
    .ref_clk(ref_clk), .rst(rst), .serialEnableN(serialEnableN),
    .serialClk(serialClk), .serialData(serialData), .resetPin(resetPin),
    .format_select_pin_lvds(strapLvds), .format_select_pin_twos(strapTwos),
    .overrangeIn(overrangeIn), .testPatternSel(testPatternSel),
    .overrange_or_serial_out_pin(pinOut), .cfg(cfg));
  asc_host_model asc_host_model_i (
    .ref_clk(ref_clk), .serialEnableN(serialEnableN),
    .serialClk(serialClk), .serialData(serialData), .readPin(pinOut));

  // Inputs move one nanosecond after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    asc_host_model_i.xfer(addr, data, unused);
  endtask : wr
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    asc_host_model_i.xfer(addr, 8'h00, got);
    `CHECK("readback", exp, got)
  endtask : rd
  function automatic asc_edge_type rise_exp(input logic lvds,
                                            input logic [2:0] code);
    case (code)
      EDGE_CODE_5: return EDGE_PLUS4;
      EDGE_CODE_6: return lvds ? EDGE_ALIGNED : EDGE_PLUS6;
      EDGE_CODE_7: return lvds ? EDGE_MINUS4 : EDGE_ALIGNED;
      default:     return EDGE_DEFAULT;
    endcase
  endfunction : rise_exp
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog: the tests need well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    badCount++;
    report_and_stop();
  end

  initial begin
    step(3);
    rst = 1'b0;
    step(6);
    `CHECK("cfg at reset", '0, cfg)
    wr(ADDR_RATE_MODE, 8'h04); // Slow clock assumed
    `CHECK("reduced rate", 1'b1, cfg.reducedRate)
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_POWER, 8'h01 << i); // Bits 6:5 kept zero
      `CHECK("power", i == 2 ? 3'b111 : 3'b001 << i, {cfg.globalPowerDown,
             cfg.coreStandby, cfg.outputDriverOff})
    end
    wr(ADDR_POWER, 8'h00);
    strapLvds = 1'b1; // Forced codes must override the strap
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_OUT_IF, m ? 8'h80 : 8'hc0);
      `CHECK("lvds mode", m[0], cfg.lvdsMode)
      for (int c = 0; c < 8; c++) begin
        wr(ADDR_CLK_PLACE, {c[2:0], c[2:0], 2'b00});
        `CHECK("rise", rise_exp(m[0], c[2:0]), cfg.risePlace)
        `CHECK("fall", EDGE_DEFAULT, cfg.fallPlace)
      end
    end
    wr(ADDR_OUT_IF, 8'h00);
    `CHECK("lvds by strap", 1'b1, cfg.lvdsMode)
    strapTwos = 1'b1;
    wr(ADDR_NUM_FORMAT, 8'h06);
    `CHECK("offset binary", 1'b0, cfg.twosComplement)
    strapTwos = 1'b0;
    wr(ADDR_NUM_FORMAT, 8'h04);
    `CHECK("twos forced", 1'b1, cfg.twosComplement)
    strapTwos = 1'b1;
    wr(ADDR_NUM_FORMAT, 8'h00);
    `CHECK("twos by strap", 1'b1, cfg.twosComplement)
    wr(ADDR_PAT_LOW, 8'ha5);
    wr(ADDR_PAT_HIGH, 8'hff); // Fixed bits set on purpose
    testPatternSel = TEST_CUSTOM;
    step(3);
    `CHECK("pattern", 14'h3fa5, cfg.customPattern)
    `CHECK("pattern on", 1'b1, cfg.customPatternOn)
    testPatternSel = 3'b100;
    step(3);
    `CHECK("pattern off", 1'b0, cfg.customPatternOn)
    wr(ADDR_OFFSET_LOOP, 8'h40);
    `CHECK("offset on", 1'b1, cfg.offsetCorrOn)
    wr(ADDR_OFFSET_LOOP, 8'h00);
    `CHECK("offset off", 1'b0, cfg.offsetCorrOn)
    wr(ADDR_RESET_READ, 8'h01);
    rd(ADDR_RATE_MODE, 8'h04);
    rd(ADDR_PAT_HIGH, 8'h3f);
    rd(8'h30, 8'h00);
    wr(ADDR_RESET_READ, 8'h80);
    `CHECK("soft reset", 1'b0, cfg.reducedRate)
    `CHECK("soft reset pat", 14'h0000, cfg.customPattern)
    overrangeIn = 1'b1; // Readout now off, pin carries overrange
    step(3);
    `CHECK("overrange pin", 1'b1, pinOut)
    wr(ADDR_RATE_MODE, 8'h04);
    resetPin = 1'b1;
    step(10);
    `CHECK("hw reset", 1'b0, cfg.reducedRate)
    resetPin = 1'b0;
    step(10);
    report_and_stop();
  end
endmodule : tb_asc_config_regs

bind asc_config_regs asc_config_regs_props asc_config_regs_props_i (
  .ref_clk(ref_clk), .rst(rst), .serialEnableN(serialEnableN),
  .resetPin(resetPin), .testPatternSel(testPatternSel), .cfg(cfg));
